// ---- dv/lcvr_host.sv ----
`timescale 1ns/1ps
module lcvr_host (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // request from the bench
  input  wire logic        go_in,
  input  wire logic        wr_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  output logic             err_out,
  // apb master side
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  output logic [3:0]       pstrb_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  assign pstrb_out = 4'hF;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      psel_out    <= 1'b0;
      penable_out <= 1'b0;
      pwrite_out  <= 1'b0;
      paddr_out   <= 12'h000;
      pwdata_out  <= 32'h0000_0000;
      done_out    <= 1'b0;
      rdata_out   <= 32'h0000_0000;
      err_out     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (!psel_out) begin
        if (go_in) begin
          psel_out   <= 1'b1;
          pwrite_out <= wr_in;
          paddr_out  <= addr_in;
          pwdata_out <= wdata_in;
        end else begin
          // idle bus must not look like the last transfer
          paddr_out  <= ~paddr_out;
          pwdata_out <= ~pwdata_out;
        end
      end else if (!penable_out) begin
        penable_out <= 1'b1;
      end else if (pready_in) begin
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        done_out    <= 1'b1;
        rdata_out   <= prdata_in;
        err_out     <= pslverr_in;
      end
    end
  end
endmodule

// ---- dv/line_code_violation_counter_readback_bench.sv ----
`timescale 1ns/1ps
module line_code_violation_counter_readback_bench;
  import lcvr_pkg::*;
  logic                clock_in = 1'b0;
  logic                rst_b_in = 1'b0;
  logic [CHANNELS-1:0] line_code_violation      = '0;
  logic                go       = 1'b0;
  logic                wr       = 1'b0;
  logic [11:0]         addr     = 12'h000;
  logic [31:0]         wdata    = 32'h0000_0000;
  logic                psel, penable, pwrite, pready, pslverr, irq, done, err;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rdata;
  logic [3:0]          pstrb;
  logic [31:0]         lfsr     = 32'h0001_4DAC;
  int                  n_mismatch = 0;
  int                  checks     = 0;
  int                  cnt [CHANNELS] = '{default: 0};
  int                  hold [CHANNELS] = '{default: 0};

  always #2.5 clock_in = ~clock_in;

  lcvr_top lcvr_top_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .line_code_violation_in(line_code_violation), .irq_out(irq));
  lcvr_host lcvr_host_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .go_in(go), .wr_in(wr),
    .addr_in(addr), .wdata_in(wdata), .done_out(done), .rdata_out(rdata), .err_out(err),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .pstrb_out(pstrb), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr));

  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge clock_in);
    go <= 1'b1;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= d;
    @(posedge clock_in);
    go <= 1'b0;
    // no wait-state count assumed; the watchdog ends a hang
    while (done !== 1'b1) @(negedge clock_in);
  endtask

  task automatic wr8(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] want);
    bus(1'b0, idx, 32'h0000_0000);
    check(rdata, want);
  endtask

  // one violation event per set bit: 4 cycles high, 8 low clears the synchroniser
  task automatic pulse(input logic [CHANNELS-1:0] m);
    @(posedge clock_in);
    line_code_violation <= m;
    repeat (4) @(posedge clock_in);
    line_code_violation <= '0;
    repeat (8) @(posedge clock_in);
    for (int c = 0; c < CHANNELS; c++) if (m[c]) cnt[c] += (cnt[c] < 65535);
  endtask

  task automatic snap();
    for (int c = 0; c < CHANNELS; c++) hold[c] = cnt[c];
  endtask

  task automatic latch_all();
    wr8(IDX_CONTROL, 8'h08);
    snap();
    wr8(IDX_CONTROL, 8'h00);
  endtask

  task automatic readall();
    for (int c = 0; c < CHANNELS; c++) begin
      for (int b = 0; b < 2; b++) begin
        wr8(IDX_CONTROL, 8'(b << CTL_BYTE_SEL));
        wr8(IDX_SELECT, 8'(8'h40 | (c + 1)));
        rd(IDX_COUNT, 32'((hold[c] >> (8 * b)) & 255));
      end
    end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #250000;
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(IDX_SELECT, 32'h0000_0000);
    rd(IDX_CONTROL, 32'h0000_0000);
    rd(IDX_COUNT, 32'h0000_0000);
    rd(IDX_RESERVED, 32'h0000_0000);
    bus(1'b0, 10'h3FF, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    repeat (6) begin
      lfsr = nxt(lfsr);
      pulse(lfsr[CHANNELS-1:0]);
    end
    pulse('1);
    latch_all();
    readall();
    wr8(IDX_COUNT, 8'hFF);
    wr8(IDX_CONTROL, 8'h00);
    wr8(IDX_SELECT, 8'h40);
    rd(IDX_COUNT, 32'h0000_0000);
    wr8(IDX_SELECT, 8'hFF);
    rd(IDX_SELECT, 32'h0000_00CF);
    rd(IDX_COUNT, 32'h0000_0000);
    wr8(IDX_SELECT, 8'h01);
    rd(IDX_COUNT, 32'h0000_0000);
    pulse('1);
    pulse('1);
    wr8(IDX_SELECT, {4'h4, SEL_LAST});
    wr8(IDX_CONTROL, 8'h02);
    hold[13] = cnt[13];
    wr8(IDX_CONTROL, 8'h00);
    readall();
    // a latch bit left high must not capture again
    wr8(IDX_CONTROL, 8'h08);
    snap();
    pulse('1);
    wr8(IDX_CONTROL, 8'h08);
    wr8(IDX_CONTROL, 8'h00);
    readall();
    wr8(IDX_SELECT, 8'h46);
    wr8(IDX_CONTROL, 8'h01);
    repeat (CLEAR_HOLD_CYC) @(posedge clock_in);
    wr8(IDX_CONTROL, 8'h00);
    cnt[5] = 0;
    latch_all();
    readall();
    wr8(IDX_CONTROL, 8'hF0);
    rd(IDX_CONTROL, 32'h0000_0010);
    repeat (CLEAR_HOLD_CYC) @(posedge clock_in);
    wr8(IDX_CONTROL, 8'h00);
    cnt = '{default: 0};
    lfsr = nxt(lfsr);
    pulse(lfsr[CHANNELS-1:0]);
    latch_all();
    readall();
    // saturation needs 65535 events per channel, too long for this run
    bus(1'b1, IDX_IRQ_MASK, 32'h0000_3FFF);
    rd(IDX_IRQ_MASK, 32'h0000_3FFF);
    bus(1'b1, IDX_IRQ_STATUS, 32'h0000_3FFF);
    rd(IDX_IRQ_STATUS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    give_verdict();
  end
endmodule

// ---- hdl/lcvr_chan.sv ----
`timescale 1ns/1ps
module lcvr_chan (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_b_in,
  // line side
  input  wire logic                 line_code_violation_in,
  // control
  input  wire logic                 clear_in,
  input  wire logic                 latch_in,
  // results
  output logic [lcvr_pkg::CNT_W-1:0] count_out,
  output logic [lcvr_pkg::CNT_W-1:0] hold_out,
  output logic                      sat_out
);
  import lcvr_pkg::*;

  // ----------------------------------------
  // violation input synchroniser
  // ----------------------------------------
  logic              viol_s1;
  logic              viol_s2;
  logic              viol_s3;
  logic              viol_lvl;
  logic [CNT_W-1:0]  next_count;
  logic [CNT_W-1:0]  next_hold;

  wire agree     = (viol_s2 == viol_s3);
  wire next_lvl  = agree ? viol_s2 : viol_lvl;
  wire viol_rise = next_lvl & ~viol_lvl;
  wire at_full   = (count_out == CNT_FULL);

  // no counting while a clear is held; stick at full scale
  assign next_count = clear_in ? CNT_ZERO :
                      (viol_rise && !at_full) ? count_out + CNT_ONE :
                      count_out;
  // latch takes the value before this edge's increment
  assign next_hold  = latch_in ? count_out : hold_out;
  assign sat_out    = viol_rise & ~clear_in & (count_out == (CNT_FULL - CNT_ONE));

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      viol_s1   <= 1'b0;
      viol_s2   <= 1'b0;
      viol_s3   <= 1'b0;
      viol_lvl  <= 1'b0;
      count_out <= CNT_ZERO;
      hold_out  <= CNT_ZERO;
    end else begin
      viol_s1   <= line_code_violation_in;
      viol_s2   <= viol_s1;
      viol_s3   <= viol_s2;
      viol_lvl  <= next_lvl;
      count_out <= next_count;
      hold_out  <= next_hold;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sat_stick_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (at_full && !clear_in) |=> (count_out == CNT_FULL))
    else $error("counter left full scale without a clear");

  count_step_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (viol_rise && !clear_in && !at_full) |=> (count_out == $past(count_out) + CNT_ONE))
    else $error("violation did not advance the counter by one");

  clear_zero_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    clear_in [*2] |-> (count_out == CNT_ZERO))
    else $error("counter not zero while clear held");

endmodule

// ---- hdl/lcvr_pkg.sv ----
package lcvr_pkg;

  // ----------------------------------------
  // channel and counter shape
  // ----------------------------------------
  localparam int          CHANNELS = 14;
  localparam int          CNT_W    = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_SELECT     = 10'h0E5;
  localparam logic [9:0] IDX_CONTROL    = 10'h0E6;
  localparam logic [9:0] IDX_RESERVED   = 10'h0E7;
  localparam logic [9:0] IDX_COUNT      = 10'h0E8;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0F0;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h0F1;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int          CTL_CLEAR_ONE = 0;
  localparam int          CTL_LATCH_ONE = 1;
  localparam int          CTL_BYTE_SEL  = 2;
  localparam int          CTL_LATCH_ALL = 3;
  localparam int          CTL_CLEAR_ALL = 4;
  localparam logic [7:0]  CTL_WMASK     = 8'h1F;
  localparam logic [7:0]  CTL_RESET     = 8'h00;

  // ----------------------------------------
  // select register fields
  // ----------------------------------------
  localparam int          SEL_CHAN_LSB  = 0;
  localparam int          SEL_READ_EN   = 6;
  localparam int          SEL_MON       = 7;
  localparam logic [7:0]  SEL_WMASK     = 8'hCF;
  localparam logic [7:0]  SEL_RESET     = 8'h00;
  localparam logic [3:0]  SEL_NONE      = 4'h0;
  localparam logic [3:0]  SEL_LAST      = 4'hE;

  // ----------------------------------------
  // interrupt registers
  // ----------------------------------------
  localparam logic [13:0] IRQ_RESET     = 14'h0000;

  // ----------------------------------------
  // timing: software hold of a clear bit
  // ----------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int CLEAR_HOLD_US  = 1;
  localparam int CLEAR_HOLD_CYC =
    (CLEAR_HOLD_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ---- hdl/lcvr_top.sv ----
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - Setting the all-channel clear bit zeroes all fourteen counters.
// - Setting the per-channel clear bit zeroes only the selected channel's counter.
// - Setting the all-channel latch bit copies all fourteen counters into their holds at once.
// - Setting the per-channel latch bit copies only the selected channel into its hold.
// - The byte-select bit picks the low byte (0, default) or the high byte (1) for reading.
// - The count byte register returns the chosen byte of the selected channel's hold.
// - After reset the count byte register reads zero: select code 0000 names no channel and readback is off.
// - The four-bit channel field of the select register addresses clear, latch and readback.
// - Each counter saturates at full scale until cleared, never wrapping.
// - Select code 0000 names no channel; codes 0001 to 1110 name channels 0 to 13.
// - Counter bytes read back only while the readback-enable bit is one (default off).
module lcvr_top (
  // clock and reset
  input  wire logic                           clock_in,
  input  wire logic                           rst_b_in,
  // apb slave
  input  wire logic                           psel_in,
  input  wire logic                           penable_in,
  input  wire logic                           pwrite_in,
  input  wire logic [11:0]                    paddr_in,
  input  wire logic [31:0]                    pwdata_in,
  input  wire logic [3:0]                     pstrb_in,
  output logic [31:0]                         prdata_out,
  output logic                                pready_out,
  output logic                                pslverr_out,
  // line side violation strobes
  input  wire logic [lcvr_pkg::CHANNELS-1:0]  line_code_violation_in,
  // interrupt
  output logic                                irq_out
);
  import lcvr_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]          control;
  logic [7:0]          select;
  logic [CHANNELS-1:0] irq_status;
  logic [CHANNELS-1:0] irq_mask;
  logic                latch_all_prev;
  logic                latch_one_prev;

  logic [CNT_W-1:0]    count_val [CHANNELS];
  logic [CNT_W-1:0]    hold_val  [CHANNELS];
  logic [CHANNELS-1:0] chan_hit;
  logic [CHANNELS-1:0] chan_clear;
  logic [CHANNELS-1:0] chan_latch;
  logic [CHANNELS-1:0] chan_sat;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire [9:0] word_idx  = paddr_in[11:2];
  wire       aligned   = (paddr_in[1:0] == 2'b00);
  wire       hit_sel   = aligned && (word_idx == IDX_SELECT);
  wire       hit_ctl   = aligned && (word_idx == IDX_CONTROL);
  wire       hit_rsv   = aligned && (word_idx == IDX_RESERVED);
  wire       hit_cnt   = aligned && (word_idx == IDX_COUNT);
  wire       hit_ists  = aligned && (word_idx == IDX_IRQ_STATUS);
  wire       hit_imsk  = aligned && (word_idx == IDX_IRQ_MASK);
  wire       mapped    = hit_sel | hit_ctl | hit_rsv | hit_cnt | hit_ists | hit_imsk;
  wire       setup     = psel_in & ~penable_in;
  wire       access    = psel_in & penable_in;
  // writes use the low two lanes only: every register is at most 14 bits
  wire       wr_lo     = access & pwrite_in & mapped & pstrb_in[0];
  wire       wr_hi     = access & pwrite_in & mapped & pstrb_in[1];

  // zero-wait slave; unmapped or misaligned words answer with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;

  // ----------------------------------------
  // control fields and channel decode
  // ----------------------------------------
  wire [3:0] chan_code   = select[SEL_CHAN_LSB +: 4];
  wire       read_en     = select[SEL_READ_EN];
  wire       byte_sel    = control[CTL_BYTE_SEL];
  wire       clear_all   = control[CTL_CLEAR_ALL];
  wire       clear_one   = control[CTL_CLEAR_ONE];
  wire       latch_all   = control[CTL_LATCH_ALL];
  wire       latch_one   = control[CTL_LATCH_ONE];
  wire       latch_all_r = latch_all & ~latch_all_prev;
  wire       latch_one_r = latch_one & ~latch_one_prev;
  wire       chan_valid  = (chan_code != SEL_NONE) && (chan_code <= SEL_LAST);
  wire [3:0] chan_index  = chan_valid ? (chan_code - 4'h1) : 4'h0;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      assign chan_hit[g]   = (chan_code == 4'(g + 1));
      assign chan_clear[g] = clear_all | (clear_one & chan_hit[g]);
      assign chan_latch[g] = latch_all_r | (latch_one_r & chan_hit[g]);

      lcvr_chan lcvr_chan_i (
        .clock_in               (clock_in),
        .rst_b_in               (rst_b_in),
        .line_code_violation_in (line_code_violation_in[g]),
        .clear_in               (chan_clear[g]),
        .latch_in               (chan_latch[g]),
        .count_out              (count_val[g]),
        .hold_out               (hold_val[g]),
        .sat_out                (chan_sat[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // readback path
  // ----------------------------------------
  wire [CNT_W-1:0] sel_hold  = chan_valid ? hold_val[chan_index] : CNT_ZERO;
  wire [7:0]       sel_byte  = byte_sel ? sel_hold[15:8] : sel_hold[7:0];
  // readback gated off reads as zero, like the "none" code
  wire [7:0]       cnt_byte  = read_en ? sel_byte : 8'h00;

  wire [31:0] rd_mux = hit_sel  ? {24'h00_0000, select} :
                       hit_ctl  ? {24'h00_0000, control} :
                       hit_cnt  ? {24'h00_0000, cnt_byte} :
                       hit_ists ? {18'h0_0000, irq_status} :
                       hit_imsk ? {18'h0_0000, irq_mask} :
                       32'h0000_0000;

  // ----------------------------------------
  // interrupt status: set wins over clear
  // ----------------------------------------
  wire [CHANNELS-1:0] ists_clr    = (wr_lo && hit_ists) ?
                                    {pwdata_in[13:8] & {6{wr_hi}}, pwdata_in[7:0]} :
                                    IRQ_RESET;
  wire [CHANNELS-1:0] next_status = (irq_status & ~ists_clr) | chan_sat;
  wire [CHANNELS-1:0] next_mask   = (wr_lo && hit_imsk) ?
                                    {wr_hi ? pwdata_in[13:8] : irq_mask[13:8],
                                     pwdata_in[7:0]} : irq_mask;
  wire [7:0] next_control = (wr_lo && hit_ctl) ? (pwdata_in[7:0] & CTL_WMASK) : control;
  wire [7:0] next_select  = (wr_lo && hit_sel) ? (pwdata_in[7:0] & SEL_WMASK) : select;

  assign irq_out = |(irq_status & irq_mask);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control <= CTL_RESET;
    end else begin
      control <= next_control;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      select <= SEL_RESET;
    end else begin
      select <= next_select;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= next_status;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_mask <= IRQ_RESET;
    end else begin
      irq_mask <= next_mask;
    end
  end

  // previous latch bits feed the zero-to-one edge detectors
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_all_prev <= 1'b0;
    end else begin
      latch_all_prev <= latch_all;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_one_prev <= 1'b0;
    end else begin
      latch_one_prev <= latch_one;
    end
  end

  // read data sampled at setup, held through the access cycle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      prdata_out <= rd_mux;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  clear_all_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    clear_all |=> (count_val[0] == CNT_ZERO) && (count_val[13] == CNT_ZERO))
    else $error("clear all left a counter non-zero");

  clear_one_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (clear_one && !clear_all && chan_code == 4'h6) |=> (count_val[5] == CNT_ZERO))
    else $error("per-channel clear missed the selected counter");

  latch_all_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $rose(latch_all) |=> (hold_val[5] == $past(count_val[5])) &&
                         (hold_val[13] == $past(count_val[13])))
    else $error("latch all did not copy counters");

  latch_one_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (latch_one_r && !latch_all_r && chan_code == SEL_LAST) |=>
      (hold_val[13] == $past(count_val[13])) && $stable(hold_val[0]))
    else $error("per-channel latch touched the wrong hold");

  latch_edge_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (latch_all && latch_all_prev && !latch_one_r) |=> $stable(hold_val[7]))
    else $error("held latch bit recaptured a counter");

  byte_pick_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && hit_cnt && read_en && chan_code == 4'h1 && byte_sel) |=>
      (prdata_out == {24'h00_0000, $past(hold_val[0][15:8])}))
    else $error("high byte read returned wrong data");

  read_off_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && hit_cnt && !read_en) |=> (prdata_out == 32'h0000_0000))
    else $error("counter readable with readback disabled");

  none_code_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && hit_cnt && chan_code == SEL_NONE) |=>
      (prdata_out == 32'h0000_0000))
    else $error("select code none returned data");

  sat_set_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (chan_sat[4]) |=> irq_status[4] ##1 (irq_status[4] || $past(ists_clr[4])))
    else $error("saturation event lost in status");

  // ----------------------------------------
  // per-channel checks
  // ----------------------------------------
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_check
      chan_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        chan_clear[g] |=> (count_val[g] == CNT_ZERO))
        else $error("cleared channel counter not zero");

      chan_latch_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        chan_latch[g] |=> (hold_val[g] == $past(count_val[g])))
        else $error("latched hold differs from its counter");

      hold_keep_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !chan_latch[g] |=> $stable(hold_val[g]))
        else $error("hold changed without a latch");
    end
  endgenerate

  // ----------------------------------------
  // register bus checks
  // ----------------------------------------
  sel_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (wr_lo && hit_sel) |=> (select == ($past(pwdata_in[7:0]) & SEL_WMASK)))
    else $error("select write not stored");

  ctl_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (wr_lo && hit_ctl) |=> (control == ($past(pwdata_in[7:0]) & CTL_WMASK)))
    else $error("control write not stored");

  ctl_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && hit_ctl) |=> (prdata_out == {24'h00_0000, $past(control)}))
    else $error("control read returned wrong data");

  low_byte_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && hit_cnt && read_en && chan_code == SEL_LAST && !byte_sel) |=>
      (prdata_out == {24'h00_0000, $past(hold_val[13][7:0])}))
    else $error("low byte read returned wrong data");

  count_wr_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (access && pwrite_in && hit_cnt) |=> ($stable(control) && $stable(select)))
    else $error("write to count byte changed a register");

  no_chan_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (chan_code == SEL_NONE || chan_code == 4'hF) |-> (chan_hit == '0))
    else $error("reserved select code addressed a channel");

  one_hit_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    chan_valid |-> $onehot(chan_hit))
    else $error("valid select code did not address one channel");

  status_clr_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (wr_lo && hit_ists && pwdata_in[0] && !chan_sat[0]) |=>
      !irq_status[0])
    else $error("status bit not cleared by a written one");

  unmapped_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && !mapped) |=> (prdata_out == 32'h0000_0000))
    else $error("unmapped read returned data");

  reserved_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (setup && !pwrite_in && hit_rsv) |=> (prdata_out == 32'h0000_0000))
    else $error("reserved slot read returned data");

endmodule
